// File: src/lvdc_pkg.sv
/*
  package of the low-voltage detect control block: register offsets, bit
  positions, reset values and the state carrier.
  assumes a byte-wide register port and one 125 MHz clock.
*/
package lvdc_pkg;

  localparam logic [1:0] OFFSET_CONTROL = 2'h0;
  localparam logic [1:0] OFFSET_IRQ_STATUS = 2'h1;
  localparam logic [1:0] OFFSET_IRQ_MASK = 2'h2;

  localparam int BIT_FLAG = 7;
  localparam int BIT_ACK = 6;
  localparam int BIT_IRQ_ENABLE = 5;
  localparam int BIT_RESET_ENABLE = 4;
  localparam int BIT_STOP_ENABLE = 3;
  localparam int BIT_DETECT_ENABLE = 2;
  localparam int BIT_RESERVED = 1;
  localparam int BIT_BUFFER_ENABLE = 0;

  localparam int EVT_DETECT = 0;
  localparam int EVT_CLEARED = 1;

  localparam logic [7:0] RESET_CONTROL = 8'h1C;
  localparam logic [1:0] RESET_EVENTS = 2'h0;

  typedef struct packed {
    logic lowVoltageFlag;
    logic lowVoltageIrqEnable;
    logic lowVoltageResetEnable;
    logic lowVoltageStopEnable;
    logic lowVoltageDetectEnable;
    logic bandgapBufferEnable;
    logic resetEnableWritten;
    logic [1:0] eventStatus;
    logic [1:0] eventMask;
    logic [7:0] readData;
    logic irqRequest;
    logic resetRequest;
    logic detectActive;
    logic eventIrq;
  } lvdc_state_type;

endpackage : lvdc_pkg

// File: src/lvdc_low_voltage_detect_control.sv
/*
  low-voltage detect control: one control/status register, a sticky event
  register with its mask, interrupt and reset requests, bandgap buffer enable.
  assumes comparator and stop inputs synchronous to clock, and a bus master
  that never strobes read and write in the same cycle.
*/
// Summary of operation
// - flag records low voltage while detect enabled
// - write one at bit 6 clears flag
// - interrupt enable raises request while flag set
// - reset enable forces system reset on flag
// - stop enable keeps detection alive in stop
// - detect enable gates flag, reset, stop behaviour
// - bit 0 turns bandgap buffer on
// - reset enable bit accepts first write only
module lvdc_low_voltage_detect_control
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData,
  input wire logic lowVoltageSense,
  input wire logic stopMode,
  output logic lowVoltageIrq,
  output logic systemResetRequest,
  output logic bandgapBufferEnable,
  output logic detectActive,
  output logic eventIrq
);

  lvdc_pkg::lvdc_state_type state;
  lvdc_pkg::lvdc_state_type next_state;
  logic writeControl;
  logic writeMask;
  logic readEvents;
  logic sensing;
  logic ackWrite;
  logic [1:0] eventSet;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_state = state;
    writeControl = writeStrobe && (address == lvdc_pkg::OFFSET_CONTROL);
    writeMask = writeStrobe && (address == lvdc_pkg::OFFSET_IRQ_MASK);
    readEvents = readStrobe && (address == lvdc_pkg::OFFSET_IRQ_STATUS);
    ackWrite = writeControl && writeData[lvdc_pkg::BIT_ACK];
    // detection runs only when enabled, and in stop only with stop enable
    sensing = state.lowVoltageDetectEnable
      && (!stopMode || state.lowVoltageStopEnable);
    eventSet = 2'h0;
    if (writeControl)
    begin
      next_state.lowVoltageIrqEnable = writeData[lvdc_pkg::BIT_IRQ_ENABLE];
      next_state.lowVoltageStopEnable = writeData[lvdc_pkg::BIT_STOP_ENABLE];
      next_state.lowVoltageDetectEnable = writeData[lvdc_pkg::BIT_DETECT_ENABLE];
      next_state.bandgapBufferEnable = writeData[lvdc_pkg::BIT_BUFFER_ENABLE];
      if (!state.resetEnableWritten)
      begin
        next_state.lowVoltageResetEnable = writeData[lvdc_pkg::BIT_RESET_ENABLE];
        next_state.resetEnableWritten = 1'b1;
      end
    end
    if (ackWrite && state.lowVoltageFlag)
    begin
      next_state.lowVoltageFlag = 1'b0;
      eventSet[lvdc_pkg::EVT_CLEARED] = 1'b1;
    end
    // a detection in the acknowledge cycle wins over the clear
    if (sensing && lowVoltageSense)
    begin
      next_state.lowVoltageFlag = 1'b1;
      eventSet[lvdc_pkg::EVT_DETECT] = !state.lowVoltageFlag;
      eventSet[lvdc_pkg::EVT_CLEARED] = 1'b0;
    end
    if (!next_state.lowVoltageDetectEnable)
    begin
      next_state.lowVoltageFlag = 1'b0;
    end
    if (writeMask)
    begin
      next_state.eventMask = writeData[1:0];
    end
    if (readEvents)
    begin
      next_state.eventStatus = eventSet;
    end
    else
    begin
      next_state.eventStatus = state.eventStatus | eventSet;
    end
    next_state.readData = 8'h00;
    if (readStrobe)
    begin
      case (address)
        lvdc_pkg::OFFSET_CONTROL:
        begin
          // acknowledge and reserved bits read zero
          next_state.readData = {state.lowVoltageFlag, 1'b0, state.lowVoltageIrqEnable,
            state.lowVoltageResetEnable, state.lowVoltageStopEnable,
            state.lowVoltageDetectEnable, 1'b0, state.bandgapBufferEnable};
        end
        lvdc_pkg::OFFSET_IRQ_STATUS: next_state.readData = {6'h00, state.eventStatus};
        lvdc_pkg::OFFSET_IRQ_MASK: next_state.readData = {6'h00, state.eventMask};
        default: next_state.readData = 8'h00;
      endcase
    end
    next_state.irqRequest = next_state.lowVoltageFlag
      && next_state.lowVoltageIrqEnable;
    next_state.resetRequest = next_state.lowVoltageFlag
      && next_state.lowVoltageResetEnable
      && next_state.lowVoltageDetectEnable;
    next_state.detectActive = next_state.lowVoltageDetectEnable
      && (!stopMode || next_state.lowVoltageStopEnable);
    next_state.eventIrq = |(next_state.eventStatus & next_state.eventMask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= '0;
      // each control field takes its own bit of the reset byte
      state.lowVoltageFlag <= lvdc_pkg::RESET_CONTROL[lvdc_pkg::BIT_FLAG];
      state.lowVoltageIrqEnable <= lvdc_pkg::RESET_CONTROL[lvdc_pkg::BIT_IRQ_ENABLE];
      state.lowVoltageResetEnable <= lvdc_pkg::RESET_CONTROL[lvdc_pkg::BIT_RESET_ENABLE];
      state.lowVoltageStopEnable <= lvdc_pkg::RESET_CONTROL[lvdc_pkg::BIT_STOP_ENABLE];
      state.lowVoltageDetectEnable <= lvdc_pkg::RESET_CONTROL[lvdc_pkg::BIT_DETECT_ENABLE];
      state.bandgapBufferEnable <= lvdc_pkg::RESET_CONTROL[lvdc_pkg::BIT_BUFFER_ENABLE];
      // the write-once bit is open again after every reset
      state.resetEnableWritten <= 1'b0;
      state.eventStatus <= lvdc_pkg::RESET_EVENTS;
      state.eventMask <= lvdc_pkg::RESET_EVENTS;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign readData = state.readData;
  assign lowVoltageIrq = state.irqRequest;
  assign systemResetRequest = state.resetRequest;
  assign bandgapBufferEnable = state.bandgapBufferEnable;
  assign detectActive = state.detectActive;
  assign eventIrq = state.eventIrq;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence lvdcSenseSeq;
    detectActive && lowVoltageSense;
  endsequence

  sequence lvdcFlagSeq;
    readStrobe && address == lvdc_pkg::OFFSET_CONTROL ##1 readData[lvdc_pkg::BIT_FLAG];
  endsequence

  AST_FLAG_SETS: assert property (@(posedge clock) disable iff (rst)
    lvdcSenseSeq |=> state.lowVoltageFlag)
    else $error("flag not set after detection");

  AST_ACK_CLEARS: assert property (@(posedge clock) disable iff (rst)
    writeControl && writeData[lvdc_pkg::BIT_ACK] && !lowVoltageSense |=> !state.lowVoltageFlag)
    else $error("acknowledge did not clear flag");

  AST_ACK_READS_ZERO: assert property (@(posedge clock) disable iff (rst)
    readStrobe && address == lvdc_pkg::OFFSET_CONTROL
    |=> !readData[lvdc_pkg::BIT_ACK] && !readData[lvdc_pkg::BIT_RESERVED])
    else $error("acknowledge bit read nonzero");

  AST_IRQ: assert property (@(posedge clock) disable iff (rst)
    lowVoltageIrq == (state.lowVoltageFlag && state.lowVoltageIrqEnable))
    else $error("interrupt request mismatch");

  AST_RESET_REQ: assert property (@(posedge clock) disable iff (rst)
    state.lowVoltageResetEnable && sensing && lowVoltageSense && !writeControl
    |=> systemResetRequest)
    else $error("reset request missing");

  AST_STOP_GATES: assert property (@(posedge clock) disable iff (rst)
    stopMode && !state.lowVoltageStopEnable && !state.lowVoltageFlag && !writeStrobe
    |=> !state.lowVoltageFlag)
    else $error("flag set in stop without stop enable");

  AST_BUFFER: assert property (@(posedge clock) disable iff (rst)
    writeControl |=> bandgapBufferEnable == $past(writeData[lvdc_pkg::BIT_BUFFER_ENABLE]))
    else $error("buffer enable not written");

  AST_WRITE_ONCE: assert property (@(posedge clock) disable iff (rst)
    writeControl && state.resetEnableWritten |=> $stable(state.lowVoltageResetEnable))
    else $error("write-once bit changed twice");

  AST_DISABLED_QUIET: assert property (@(posedge clock) disable iff (rst)
    !state.lowVoltageDetectEnable |-> !state.lowVoltageFlag ##1 !systemResetRequest)
    else $error("disabled detector raised flag or reset");

  AST_FLAG_READ: assert property (@(posedge clock) disable iff (rst)
    lvdcFlagSeq |-> $past(state.lowVoltageFlag))
    else $error("flag read does not match state");

  sequence lvdcQuietSeq;
    !state.lowVoltageFlag && !(sensing && lowVoltageSense);
  endsequence

  sequence lvdcHeldSeq;
    state.lowVoltageFlag && !writeControl;
  endsequence

  AST_FLAG_HOLDS: assert property (@(posedge clock) disable iff (rst)
    lvdcHeldSeq |=> state.lowVoltageFlag)
    else $error("flag dropped without acknowledge");

  AST_FLAG_ONLY_SENSE: assert property (@(posedge clock) disable iff (rst)
    lvdcQuietSeq |=> !state.lowVoltageFlag)
    else $error("flag set without detection");

  AST_SENSE_WINS: assert property (@(posedge clock) disable iff (rst)
    ackWrite && sensing && lowVoltageSense && writeData[lvdc_pkg::BIT_DETECT_ENABLE]
    |=> state.lowVoltageFlag)
    else $error("acknowledge won over detection");

  AST_READ_FLAG_BIT: assert property (@(posedge clock) disable iff (rst)
    readStrobe && address == lvdc_pkg::OFFSET_CONTROL
    |=> readData[lvdc_pkg::BIT_FLAG] == $past(state.lowVoltageFlag))
    else $error("flag bit read wrong");

  AST_IRQ_OFF: assert property (@(posedge clock) disable iff (rst)
    !state.lowVoltageIrqEnable |-> !lowVoltageIrq)
    else $error("interrupt request while disabled");

  AST_IRQ_ON: assert property (@(posedge clock) disable iff (rst)
    state.lowVoltageFlag && state.lowVoltageIrqEnable |-> lowVoltageIrq)
    else $error("interrupt request missing");

  AST_IRQEN_WRITE: assert property (@(posedge clock) disable iff (rst)
    writeControl
    |=> state.lowVoltageIrqEnable == $past(writeData[lvdc_pkg::BIT_IRQ_ENABLE]))
    else $error("interrupt enable not written");

  AST_RESET_OFF: assert property (@(posedge clock) disable iff (rst)
    !state.lowVoltageResetEnable |-> !systemResetRequest)
    else $error("reset request while reset disabled");

  AST_RESET_LEVEL: assert property (@(posedge clock) disable iff (rst)
    state.lowVoltageFlag && state.lowVoltageResetEnable && state.lowVoltageDetectEnable
    |-> systemResetRequest)
    else $error("reset request not held");

  AST_STOP_ACTIVE: assert property (@(posedge clock) disable iff (rst)
    stopMode && state.lowVoltageStopEnable && state.lowVoltageDetectEnable
    && lowVoltageSense && !writeControl |=> state.lowVoltageFlag)
    else $error("detection lost in stop with stop enable");

  AST_STOPEN_WRITE: assert property (@(posedge clock) disable iff (rst)
    writeControl
    |=> state.lowVoltageStopEnable == $past(writeData[lvdc_pkg::BIT_STOP_ENABLE]))
    else $error("stop enable not written");

  AST_DETECT_ACTIVE_OFF: assert property (@(posedge clock) disable iff (rst)
    !state.lowVoltageDetectEnable |-> !detectActive)
    else $error("detector active while disabled");

  AST_DETECT_WRITE: assert property (@(posedge clock) disable iff (rst)
    writeControl
    |=> state.lowVoltageDetectEnable == $past(writeData[lvdc_pkg::BIT_DETECT_ENABLE]))
    else $error("detect enable not written");

  AST_RESET_NEEDS_DETECT: assert property (@(posedge clock) disable iff (rst)
    !state.lowVoltageDetectEnable |-> !systemResetRequest)
    else $error("reset request with detector disabled");

  AST_BUFFER_HOLD: assert property (@(posedge clock) disable iff (rst)
    !writeControl |=> $stable(bandgapBufferEnable))
    else $error("buffer enable changed without write");

  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst)
    readStrobe && address == lvdc_pkg::OFFSET_CONTROL |=> !readData[lvdc_pkg::BIT_RESERVED])
    else $error("reserved bit read nonzero");

  AST_FIRST_WRITE: assert property (@(posedge clock) disable iff (rst)
    writeControl && !state.resetEnableWritten
    |=> state.lowVoltageResetEnable == $past(writeData[lvdc_pkg::BIT_RESET_ENABLE]))
    else $error("first write to reset enable lost");

  AST_WRITTEN_STICKS: assert property (@(posedge clock) disable iff (rst)
    state.resetEnableWritten |=> state.resetEnableWritten)
    else $error("write-once lock released");

  AST_RESET_EN_HOLD: assert property (@(posedge clock) disable iff (rst)
    !writeControl |=> $stable(state.lowVoltageResetEnable))
    else $error("reset enable changed without write");

  AST_DISABLED_NO_IRQ: assert property (@(posedge clock) disable iff (rst)
    !state.lowVoltageDetectEnable |-> !lowVoltageIrq)
    else $error("interrupt request with detector disabled");

  AST_DETECT_CLEAR_FLAG: assert property (@(posedge clock) disable iff (rst)
    writeControl && !writeData[lvdc_pkg::BIT_DETECT_ENABLE] |=> !state.lowVoltageFlag)
    else $error("flag kept after detector disabled");

  AST_READ_IDLE_ZERO: assert property (@(posedge clock) disable iff (rst)
    !readStrobe |=> readData == 8'h00)
    else $error("read data not zero outside read");

  AST_EVENT_STICKY: assert property (@(posedge clock) disable iff (rst)
    state.eventStatus[lvdc_pkg::EVT_DETECT] && !readEvents
    |=> state.eventStatus[lvdc_pkg::EVT_DETECT])
    else $error("detect event lost without read");

  AST_EVENT_IRQ: assert property (@(posedge clock) disable iff (rst)
    |(state.eventStatus & state.eventMask) |-> eventIrq)
    else $error("event interrupt missing");

endmodule // lvdc_low_voltage_detect_control

// File: verification/lvdc_comparator_model.sv
/*
  comparator and stop-mode source in front of the low-voltage detect control.
  assumes the bench asks for supply dips and stop on clock edges.
*/
module lvdc_comparator_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic lowSupply,
  input wire logic stopRequest,
  output logic lowVoltageSense,
  output logic stopMode
);
  timeunit 1ns;
  timeprecision 1ps;
  // comparator output is resynchronised so the block sees a clean level
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lowVoltageSense <= 1'b0;
      stopMode <= 1'b0;
    end
    else
    begin
      lowVoltageSense <= lowSupply;
      stopMode <= stopRequest;
    end
  end
endmodule // lvdc_comparator_model

// File: verification/lvdc_testbench.sv
/*
  self-checking bench of the low-voltage detect control block.
  assumes the design and comparator model sources are compiled before it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, writeStrobe = 1'b0, readStrobe = 1'b0;
  logic lowSupply = 1'b0, stopRequest = 1'b0, pending = 1'b0;
  logic [1:0] address = 2'h0;
  logic [7:0] writeData = 8'h00, readData, expVal, r;
  logic lowVoltageSense, stopMode, lowVoltageIrq, systemResetRequest;
  logic bandgapBufferEnable, detectActive, eventIrq;
  logic [7:0] expQ[$];
  int err_count = 0, compares = 0;
  lvdc_low_voltage_detect_control dut (.clock(clock), .rst(rst), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .lowVoltageSense(lowVoltageSense), .stopMode(stopMode),
    .lowVoltageIrq(lowVoltageIrq), .systemResetRequest(systemResetRequest),
    .bandgapBufferEnable(bandgapBufferEnable), .detectActive(detectActive),
    .eventIrq(eventIrq));
  lvdc_comparator_model partner (.clock(clock), .rst(rst), .lowSupply(lowSupply),
    .stopRequest(stopRequest), .lowVoltageSense(lowVoltageSense), .stopMode(stopMode));
  initial
  begin
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    expQ.push_back(exp);
    @(posedge clock);
    readStrobe <= 1'b0;
  endtask
  task automatic dip();
    @(posedge clock);
    lowSupply <= 1'b1;
    repeat (2) @(posedge clock);
    lowSupply <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge clock)
  begin
    if (pending === 1'b1)
    begin
      expVal = expQ.pop_front();
      chk(readData, expVal);
    end
    pending = readStrobe;
  end
  initial
  begin
    #20us;
    err_count++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hA1AC));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(2'h0, 8'h1C);
    rd(2'h3, 8'h00);
    dip();
    chk({7'h0, systemResetRequest}, 8'h01);
    chk({7'h0, lowVoltageIrq}, 8'h00);
    rd(2'h0, 8'h9C);
    wr(2'h2, 8'h03);
    wr(2'h0, 8'h65);
    rd(2'h0, 8'h25);
    chk({7'h0, bandgapBufferEnable}, 8'h01);
    chk({7'h0, systemResetRequest}, 8'h00);
    chk({7'h0, eventIrq}, 8'h01);
    rd(2'h1, 8'h03);
    rd(2'h1, 8'h00);
    chk({7'h0, eventIrq}, 8'h00);
    wr(2'h0, 8'h35);
    rd(2'h0, 8'h25);
    dip();
    chk({7'h0, lowVoltageIrq}, 8'h01);
    chk({7'h0, systemResetRequest}, 8'h00);
    wr(2'h0, 8'h64);
    stopRequest <= 1'b1;
    repeat (3) @(posedge clock);
    chk({7'h0, detectActive}, 8'h00);
    dip();
    rd(2'h0, 8'h24);
    wr(2'h0, 8'h2C);
    @(posedge clock);
    chk({7'h0, detectActive}, 8'h01);
    dip();
    rd(2'h0, 8'hAC);
    stopRequest <= 1'b0;
    wr(2'h0, 8'h28);
    dip();
    rd(2'h0, 8'h28);
    chk({7'h0, lowVoltageIrq}, 8'h00);
    repeat (4)
    begin
      r = 8'($urandom) & 8'h29;
      wr(2'h0, r);
      rd(2'h0, r);
      chk({7'h0, bandgapBufferEnable}, {7'h0, r[0]});
    end
    repeat (3) @(posedge clock);
    // second reset reopens the write-once bit
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(2'h0, 8'h1C);
    wr(2'h0, 8'h04);
    wr(2'h0, 8'h14);
    rd(2'h0, 8'h04);
    repeat (3) @(posedge clock);
    give_verdict();
  end
endmodule // testbench
